// File: verilog/pcs_regs.vh
// pcs_regs.vh: register offsets, field positions, reset values and timing counts
// for the peer clock sync sampling timer; included by the design file and the bench top.
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define PCS_OFF_CTRL 12'h000
`define PCS_OFF_PERIOD_INT 12'h004
`define PCS_OFF_PERIOD_FRAC 12'h008
`define PCS_OFF_STAMPS 12'h00c
`define PCS_OFF_SYNC_RES 12'h010
`define PCS_OFF_PHASE_IN 12'h014
`define PCS_OFF_FREQ_IN 12'h018
`define PCS_OFF_GAINS 12'h01c
`define PCS_OFF_FILT_OUT 12'h020
`define PCS_OFF_COUNTERS 12'h024
`define PCS_OFF_CAPTURE 12'h028

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PCS_CTRL_RUN 0
`define PCS_CTRL_SLOW 1
`define PCS_CTRL_FREQ_VALID 2
`define PCS_CTRL_CALC 3
`define PCS_CTRL_FILT_STEP 4
`define PCS_CAP_TX 0
`define PCS_CAP_RX 1

// ----------------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------------
`define PCS_PERIOD_INT_RST 16'h0d00
`define PCS_PERIOD_FRAC_RST 16'h0000
`define PCS_GAINS_RST 32'h00040010
`define PCS_SAMPLES_PER_RELOAD 2'h3
`define PCS_CYCLES_PER_UPDATE_SLOW 2'h2
`define PCS_RTD_WRAP 10'h100
`define PCS_OFS_WRAP 10'h080
`define PCS_JITTER_US 130
`define PCS_CLK_MHZ 125
`define PCS_JITTER_CYC ((`PCS_JITTER_US * `PCS_CLK_MHZ))
`define PCS_RESP_SLVERR 2'h2
`define PCS_RESP_OKAY 2'h0

`endif

// File: verilog/pcs_timer.v
// pcs_timer.v: sampling clock, stamp counter, round trip/offset arithmetic and PI loop
// filter of the peer clock sync core, with an AXI4-Lite register slave.
// assumes: one 125 MHz clock, synchronous active-high reset, inputs synchronous.
`include "pcs_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R1) a equals second-oldest stamp minus oldest stamp.
// (R2) b is newest minus previous; delay a+b, offset (a-b)/2.
// (R3) stamps unsigned and wrapping; differences and offset signed, delay positive.
// (R4) second-oldest above second-newest: delay minus 256, offset minus 128.
// (R5) oldest above newest: delay plus 256, offset plus 128.
// (R6) integer offset scaled to radians by pi/32 (fixed point output).
// (R7) stamps captured from sample counter at message tx/rx instant, low jitter.
// (R8) any fixed stamp bias must match on every terminal.
// (R9) two-terminal phase deviation: half atan2 of negated remote*conj(local).
// (R10) filter fed once per cycle fast channel, every three cycles slow.
// (R11) phase deviation passes a proportional-plus-integral stage.
// (R12) frequency input used when valid, otherwise zero.
// (R13) frequency and phase integrators share one accumulator.
// (R14) three fixed gains: integral, proportional, frequency.
// (R15) sample at each counter expiry; reload after four samples.
// (R16) period held as 16-bit integer and 16-bit fraction registers.
// (R17) fraction added at reload; carry loads integer plus one once.
// (R18) fraction accumulator never cleared, even on period change.
// (R19) 8-bit stamp counter increments each sample, wraps 255 to 0.
// (R20) a time stamp is a direct read of the stamp counter.
// (R21) sequence number is upper four bits of stamp counter.
// (R22) messages carry stamps and sequence number separately.
// (R23) differences done signed, ten bits wide, before corrections.
module pcs_timer (
  input wire REF_CLK,
  input wire RST,
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire TX_START,
  input wire RX_START,
  output reg SAMPLE_STROBE,
  output reg CYCLE_START,
  output reg [7:0] STAMP,
  output reg [3:0] SEQ_NUM,
  output reg FILTER_STROBE
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [4:0] ctrl_q;
  reg [15:0] period_int_q;
  reg [15:0] period_frac_q;
  reg [31:0] stamps_q;
  reg [31:0] phase_in_q;
  reg [31:0] freq_in_q;
  reg [31:0] gains_q;
  reg [31:0] sync_res_q;
  reg [31:0] filt_out_q;
  reg [31:0] integ_q;
  reg [15:0] cnt_q;
  reg [15:0] frac_acc_q;
  reg [1:0] samp_in_grp_q;
  reg [7:0] stamp_q;
  reg [1:0] upd_div_q;
  reg [15:0] capture_q;
  reg calc_go;
  reg filt_go;

  // --------------------------------------------------------------------------
  // write channel: address and data taken in either order
  // --------------------------------------------------------------------------
  reg aw_held_q;
  reg w_held_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire aw_have = aw_held_q | (S_AXI_AWVALID & S_AXI_AWREADY);
  wire w_have = w_held_q | (S_AXI_WVALID & S_AXI_WREADY);
  wire [11:0] wa = aw_held_q ? awaddr_q : S_AXI_AWADDR;
  wire [31:0] wd = w_held_q ? wdata_q : S_AXI_WDATA;
  wire [3:0] ws = w_held_q ? wstrb_q : S_AXI_WSTRB;
  wire wr_fire = aw_have & w_have & ~S_AXI_BVALID;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  wire wr_ok = (wa == `PCS_OFF_CTRL) || (wa == `PCS_OFF_PERIOD_INT) ||
               (wa == `PCS_OFF_PERIOD_FRAC) || (wa == `PCS_OFF_STAMPS) ||
               (wa == `PCS_OFF_PHASE_IN) || (wa == `PCS_OFF_FREQ_IN) ||
               (wa == `PCS_OFF_GAINS);
  wire [31:0] ctrl_new = merge({27'h0, ctrl_q}, wd, ws);
  // merge works on whole words, only the low half of these lands in a register
  wire [31:0] pint_new = merge({16'h0, period_int_q}, wd, ws);
  wire [31:0] pfrac_new = merge({16'h0, period_frac_q}, wd, ws);

  always @(posedge REF_CLK) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `PCS_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      ctrl_q <= 5'h01;
      period_int_q <= `PCS_PERIOD_INT_RST;
      period_frac_q <= `PCS_PERIOD_FRAC_RST;
      stamps_q <= 32'h0;
      phase_in_q <= 32'h0;
      freq_in_q <= 32'h0;
      gains_q <= `PCS_GAINS_RST;
      calc_go <= 1'b0;
      filt_go <= 1'b0;
    end else begin
      calc_go <= 1'b0;
      filt_go <= 1'b0;
      // ready toggles while idle; a taken half is parked until its partner arrives
      S_AXI_AWREADY <= ~aw_have & ~S_AXI_AWREADY;
      S_AXI_WREADY <= ~w_have & ~S_AXI_WREADY;
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        S_AXI_AWREADY <= 1'b0;
        S_AXI_WREADY <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
        case (wa)
          `PCS_OFF_CTRL: begin
            // calc and step bits are self-clearing triggers
            ctrl_q <= {2'b00, ctrl_new[2:0]};
            calc_go <= ctrl_new[`PCS_CTRL_CALC];
            filt_go <= ctrl_new[`PCS_CTRL_FILT_STEP];
          end
          // fraction accumulator deliberately left alone on period change [R18]
          `PCS_OFF_PERIOD_INT: period_int_q <= pint_new[15:0];
          `PCS_OFF_PERIOD_FRAC: period_frac_q <= pfrac_new[15:0];
          `PCS_OFF_STAMPS: stamps_q <= merge(stamps_q, wd, ws);
          `PCS_OFF_PHASE_IN: phase_in_q <= merge(phase_in_q, wd, ws);
          `PCS_OFF_FREQ_IN: freq_in_q <= merge(freq_in_q, wd, ws);
          `PCS_OFF_GAINS: gains_q <= merge(gains_q, wd, ws); // [R14]
          default: ;
        endcase
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      `PCS_OFF_CTRL: rd_mux = {27'h0, ctrl_q};
      `PCS_OFF_PERIOD_INT: rd_mux = {16'h0, period_int_q};
      `PCS_OFF_PERIOD_FRAC: rd_mux = {16'h0, period_frac_q};
      `PCS_OFF_STAMPS: rd_mux = stamps_q;
      `PCS_OFF_SYNC_RES: rd_mux = sync_res_q;
      `PCS_OFF_PHASE_IN: rd_mux = phase_in_q;
      `PCS_OFF_FREQ_IN: rd_mux = freq_in_q;
      `PCS_OFF_GAINS: rd_mux = gains_q;
      `PCS_OFF_FILT_OUT: rd_mux = filt_out_q;
      // live stamp counter read, sequence number packed beside it [R20] [R22]
      `PCS_OFF_COUNTERS: rd_mux = {frac_acc_q, 4'h0, stamp_q[7:4], stamp_q};
      `PCS_OFF_CAPTURE: rd_mux = {16'h0, capture_q};
      default: begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `PCS_RESP_OKAY;
    end else begin
      // address only offered while no answer stands, so one read is in flight
      S_AXI_ARREADY <= 1'b0;
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= rd_ok ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end else if (S_AXI_RVALID) begin
        if (S_AXI_RREADY)
          S_AXI_RVALID <= 1'b0;
      end else if (S_AXI_ARVALID) begin
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // sampling counter with fractional reload
  // --------------------------------------------------------------------------
  // a period value of n gives n+1 clocks per sample; only the reload adds the carry
  wire expire = ctrl_q[`PCS_CTRL_RUN] && (cnt_q == 16'h0000);
  wire reload = expire && (samp_in_grp_q == `PCS_SAMPLES_PER_RELOAD);
  wire [16:0] frac_sum = {1'b0, frac_acc_q} + {1'b0, period_frac_q};
  wire [15:0] load_val = period_int_q + {15'h0, frac_sum[16]};

  always @(posedge REF_CLK) begin
    if (RST) begin
      cnt_q <= `PCS_PERIOD_INT_RST;
      frac_acc_q <= 16'h0000;
      samp_in_grp_q <= 2'h0;
      stamp_q <= 8'h00;
      upd_div_q <= 2'h0;
      SAMPLE_STROBE <= 1'b0;
      CYCLE_START <= 1'b0;
      FILTER_STROBE <= 1'b0;
      STAMP <= 8'h00;
      SEQ_NUM <= 4'h0;
    end else begin
      SAMPLE_STROBE <= expire; // [R15]
      CYCLE_START <= expire && (stamp_q[5:0] == 6'h3f);
      FILTER_STROBE <= 1'b0;
      STAMP <= stamp_q;
      SEQ_NUM <= stamp_q[7:4]; // [R21]
      if (expire) begin
        samp_in_grp_q <= samp_in_grp_q + 2'h1;
        stamp_q <= stamp_q + 8'h01; // wraps 255 to 0 on its own [R19]
        if (stamp_q[5:0] == 6'h3f) begin
          // one filter update per cycle, or one per three on slow channel [R10]
          if (!ctrl_q[`PCS_CTRL_SLOW] || upd_div_q == `PCS_CYCLES_PER_UPDATE_SLOW) begin
            FILTER_STROBE <= 1'b1;
            upd_div_q <= 2'h0;
          end else begin
            upd_div_q <= upd_div_q + 2'h1;
          end
        end
      end
      if (reload) begin
        frac_acc_q <= frac_sum[15:0]; // [R17] [R18]
        cnt_q <= load_val; // carry adds one for this period only [R17] [R16]
      end else if (expire) begin
        cnt_q <= period_int_q; // [R16]
      end else if (ctrl_q[`PCS_CTRL_RUN]) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // stamp capture at message start, same one-cycle latency both ways
  // --------------------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (RST) begin
      capture_q <= 16'h0;
    end else begin
      // identical path for tx and rx keeps any bias equal on all ends [R7] [R8]
      if (TX_START)
        capture_q[7:0] <= stamp_q;
      if (RX_START)
        capture_q[15:8] <= stamp_q;
    end
  end

  // --------------------------------------------------------------------------
  // round trip and offset: stamps_q = {newest, prev, second-oldest, oldest}
  // --------------------------------------------------------------------------
  // t3 is the oldest stamp, t0 the newest
  wire [7:0] t3 = stamps_q[7:0];
  wire [7:0] t2 = stamps_q[15:8];
  wire [7:0] t1 = stamps_q[23:16];
  wire [7:0] t0 = stamps_q[31:24];
  // ten bits so sums and corrections cannot overflow [R23] [R3]
  wire signed [9:0] dif_a = $signed({2'b00, t2}) - $signed({2'b00, t3}); // [R1]
  wire signed [9:0] dif_b = $signed({2'b00, t0}) - $signed({2'b00, t1}); // [R2]
  wire signed [9:0] rtd_raw = dif_a + dif_b; // [R2]
  wire signed [9:0] ofs2_raw = dif_a - dif_b;
  wire signed [9:0] ofs_raw = ofs2_raw >>> 1; // [R2]
  reg signed [9:0] rtd_c;
  reg signed [9:0] ofs_c;
  always @* begin
    rtd_c = rtd_raw;
    ofs_c = ofs_raw;
    if (t2 > t1) begin
      rtd_c = rtd_c - $signed(`PCS_RTD_WRAP); // [R4]
      ofs_c = ofs_c - $signed(`PCS_OFS_WRAP); // [R4]
    end
    if (t3 > t0) begin
      rtd_c = rtd_c + $signed(`PCS_RTD_WRAP); // [R5]
      ofs_c = ofs_c + $signed(`PCS_OFS_WRAP); // [R5]
    end
  end
  // radians in q.8: offset*pi/32 with pi/32 ~ 25/256 [R6]
  wire signed [17:0] ofs_rad = ofs_c * $signed(8'sd25);

  always @(posedge REF_CLK) begin
    if (RST) begin
      sync_res_q <= 32'h0;
    end else if (calc_go) begin
      // delay kept unsigned positive, offset signed [R3]
      sync_res_q <= {ofs_rad[13:0], ofs_c[7:0], rtd_c[9:0]};
    end
  end

  // --------------------------------------------------------------------------
  // PI loop filter with frequency input on a single shared integrator
  // phase_in_q holds the current-derived deviation (atan2(-im,-re)/2) [R9]
  // --------------------------------------------------------------------------
  wire [15:0] integral_gain = {8'h00, gains_q[7:0]};
  wire [15:0] proportional_gain = {8'h00, gains_q[15:8]};
  wire [15:0] frequency_gain = gains_q[31:16];
  // frequency term is zero unless software marks it valid [R12]
  wire signed [15:0] freq_term = ctrl_q[`PCS_CTRL_FREQ_VALID] ? freq_in_q[15:0] : 16'sh0000;
  wire signed [15:0] ph = phase_in_q[15:0];
  wire signed [31:0] ki_term = ph * $signed({1'b0, integral_gain[14:0]});
  wire signed [31:0] kf_term = freq_term * $signed({1'b0, frequency_gain[14:0]});
  wire signed [31:0] kp_term = ph * $signed({1'b0, proportional_gain[14:0]});
  wire filt_step = FILTER_STROBE | filt_go;

  // --------------------------------------------------------------------------
  // filter update
  // --------------------------------------------------------------------------
  // accumulator wraps at 32 bits; gains must keep the loop well inside that
  always @(posedge REF_CLK) begin
    if (RST) begin
      integ_q <= 32'h0;
      filt_out_q <= 32'h0;
    end else if (filt_step) begin
      // one accumulator for both paths so they cannot drift apart [R13] [R11]
      integ_q <= integ_q + ki_term + kf_term; // [R14]
      filt_out_q <= integ_q + ki_term + kf_term + kp_term; // [R11]
    end
  end

endmodule
`default_nettype wire

// File: tb/pcs_timer_sva.sv
// pcs_timer_sva.sv: port checks for the sync timer
// assumes: bound to pcs_timer, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module pcs_timer_sva (
  input wire REF_CLK,
  input wire RST,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire SAMPLE_STROBE,
  input wire CYCLE_START,
  input wire [7:0] STAMP,
  input wire [3:0] SEQ_NUM,
  input wire FILTER_STROBE
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_ar_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_stamp_moved;
    !$stable(STAMP);
  endsequence
  a_read_answer: assert property (s_ar_taken |=> S_AXI_RVALID)
    else $error("read not answered");
  a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP)) else $error("read dropped");
  a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
  a_seq_upper: assert property (SEQ_NUM == STAMP[7:4])
    else $error("sequence number not upper stamp bits");
  a_stamp_step: assert property (s_stamp_moved |-> STAMP == $past(STAMP) + 8'h01)
    else $error("stamp did not step by one");
  a_stamp_rate: assert property (s_stamp_moved |->
    (SAMPLE_STROBE || $past(SAMPLE_STROBE) || $past(SAMPLE_STROBE, 2)))
    else $error("stamp moved without a sample");
  a_sample_pulse: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
    else $error("sample strobe too long");
  a_cycle_pulse: assert property (CYCLE_START |=> !CYCLE_START)
    else $error("cycle start too long");
  a_cycle_mark: assert property (CYCLE_START |-> ##[0:2] (STAMP[5:0] == 6'h00))
    else $error("cycle start off a cycle boundary");
  a_filter_cycle: assert property (FILTER_STROBE |-> CYCLE_START)
    else $error("filter update off a cycle start");
endmodule
`default_nettype wire

// File: tb/pcs_peer_model.sv
// pcs_peer_model.sv: far terminal raising message tx and rx instants
// assumes: go held until done; stamp is the timer's STAMP port
`timescale 1ns/1ps
`default_nettype none
module pcs_peer_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] stamp,
  output logic tx_start,
  output logic rx_start,
  output logic [7:0] tx_stamp,
  output logic [7:0] rx_stamp,
  output logic done
);
  logic [7:0] last;
  // ---------------------------------------------------------------
  // exchange
  // ---------------------------------------------------------------
  // instants sit mid-sample so the seen and captured stamps agree
  task automatic mid_sample();
    last = stamp;
    while (stamp === last) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  initial begin
    tx_start = 1'b0;
    rx_start = 1'b0;
    tx_stamp = 8'h00;
    rx_stamp = 8'h00;
    done = 1'b0;
    forever begin
      @(posedge clk);
      if (go && !done) begin
        mid_sample();
        tx_stamp <= stamp; // zero bias on both ends
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        mid_sample();
        mid_sample();
        rx_stamp <= stamp;
        rx_start <= 1'b1;
        @(posedge clk);
        rx_start <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/pcs_timer_tb_top.sv
// pcs_timer_tb_top.sv: self-checking bench for the sync timer
// assumes: design, header, checker and peer model compiled first
`include "pcs_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module pcs_timer_tb_top;
  logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, go, slow;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rd, st;
  logic [3:0] wstrb;
  logic [7:0] r;
  wire awready, wready, bvalid, arready, rvalid, tx_s, rx_s, smp, cyc, flt, done;
  wire [1:0] bresp, rresp;
  wire [7:0] stamp, tx_st, rx_st;
  wire [31:0] rdata;
  wire [3:0] seq;
  int errors, comparisons, integ, c, d1, d2, h, o, ph, f, ki, kp, kf, nsmp, nflt;
  pcs_timer pcs_timer_i (.REF_CLK(ref_clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TX_START(tx_s), .RX_START(rx_s), .SAMPLE_STROBE(smp), .CYCLE_START(cyc),
    .STAMP(stamp), .SEQ_NUM(seq), .FILTER_STROBE(flt));
  pcs_peer_model pcs_peer_model_i (.clk(ref_clk), .go(go), .stamp(stamp), .tx_start(tx_s),
    .rx_start(rx_s), .tx_stamp(tx_st), .rx_stamp(rx_st), .done(done));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    @(posedge ref_clk);
    {aw_ok, w_ok, b_ok} = 3'b000;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!b_ok) begin
      @(posedge ref_clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        b_ok = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end
  endtask
  task automatic rdx(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ok;
    @(posedge ref_clk);
    ok = 1'b0;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!ok) begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
  endtask
  task automatic strobes(input int n, output int cy);
    cy = 0;
    while (n > 0) begin
      @(posedge ref_clk);
      cy++;
      if (smp === 1'b1) n--;
    end
  endtask
  function automatic logic [31:0] exp_sync(input logic [31:0] s);
    logic signed [9:0] a, b, rtd, ofs;
    logic signed [13:0] rad;
    a = $signed({2'b00, s[15:8]}) - $signed({2'b00, s[7:0]});
    b = $signed({2'b00, s[31:24]}) - $signed({2'b00, s[23:16]});
    rtd = a + b;
    ofs = (a - b) >>> 1;
    if (s[15:8] > s[23:16]) {rtd, ofs} = {rtd - 10'sd256, ofs - 10'sd128};
    if (s[7:0] > s[31:24]) {rtd, ofs} = {rtd + 10'sd256, ofs + 10'sd128};
    rad = 14'(ofs * 25);
    return {rad, ofs[7:0], rtd};
  endfunction
  // samples between two filter updates: one cycle, or three on the slow channel
  always @(posedge ref_clk) begin
    if (rst === 1'b0) begin
      if (smp === 1'b1) nsmp++;
      if (flt === 1'b1) begin
        if (nflt > 0) chk(32'(nsmp), slow ? 32'd192 : 32'd64);
        nflt++;
        nsmp = 0;
      end
    end
  end
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, go} = 7'b1000000;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hf};
    errors = 0;
    comparisons = 0;
    slow = 1'b0;
    st = $urandom(32'hd1f5);
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rdx(`PCS_OFF_CTRL, `PCS_RESP_OKAY, rd);
    chk(rd, 32'h1);
    rdx(`PCS_OFF_PERIOD_INT, `PCS_RESP_OKAY, rd);
    chk(rd, {16'h0, `PCS_PERIOD_INT_RST});
    rdx(`PCS_OFF_PERIOD_FRAC, `PCS_RESP_OKAY, rd);
    chk(rd, {16'h0, `PCS_PERIOD_FRAC_RST});
    rdx(`PCS_OFF_GAINS, `PCS_RESP_OKAY, rd);
    chk(rd, `PCS_GAINS_RST);
    rdx(12'h100, `PCS_RESP_SLVERR, rd);
    chk(rd, 32'h0);
    wr(`PCS_OFF_SYNC_RES, 32'h1, `PCS_RESP_SLVERR);
    wr(12'h200, 32'h1, `PCS_RESP_SLVERR);
    // stamp sets: two wrap corners, then random exchanges
    for (int i = 0; i < 14; i++) begin
      r = (i == 0) ? 8'hf8 : (i == 1) ? 8'he0 : 8'($urandom);
      d1 = (i < 2) ? 10 : $urandom_range(40);
      d2 = (i < 2) ? 10 : $urandom_range(40);
      h = (i < 2) ? 5 : $urandom_range(30);
      o = (i < 2) ? i * 20 : $urandom_range(60) - 30;
      st = {8'(r + d1 + h + d2), 8'(r + d1 + o + h), 8'(r + d1 + o), r};
      wr(`PCS_OFF_STAMPS, st, `PCS_RESP_OKAY);
      wr(`PCS_OFF_CTRL, 32'h9, `PCS_RESP_OKAY);
      rdx(`PCS_OFF_SYNC_RES, `PCS_RESP_OKAY, rd);
      chk(rd, exp_sync(st));
    end
    // loop filter, stepped by hand while the cycle strobe is far off
    {ki, kp, kf} = {$urandom_range(15), $urandom_range(15), $urandom_range(15)};
    {ph, f} = {$urandom_range(255), $urandom_range(255)};
    wr(`PCS_OFF_GAINS, {kf[15:0], kp[7:0], ki[7:0]}, `PCS_RESP_OKAY);
    wr(`PCS_OFF_PHASE_IN, 32'(ph), `PCS_RESP_OKAY);
    wr(`PCS_OFF_FREQ_IN, 32'(f), `PCS_RESP_OKAY);
    integ = 0;
    for (int j = 0; j < 2; j++) begin
      if (j == 1) wr(`PCS_OFF_CTRL, 32'h5, `PCS_RESP_OKAY);
      wr(`PCS_OFF_CTRL, (j == 1) ? 32'h15 : 32'h11, `PCS_RESP_OKAY);
      integ = integ + ph * ki + ((j == 1) ? f * kf : 0);
      rdx(`PCS_OFF_FILT_OUT, `PCS_RESP_OKAY, rd);
      chk(rd, 32'(integ + ph * kp));
    end
    // fractional reload: 16 samples hold four reloads, so k carries
    wr(`PCS_OFF_PERIOD_INT, 32'h7, `PCS_RESP_OKAY);
    for (int k = 1; k < 4; k++) begin
      wr(`PCS_OFF_PERIOD_FRAC, 32'(k * 16'h4000), `PCS_RESP_OKAY);
      strobes(6, c);
      strobes(16, c);
      chk(32'(c), 32'(128 + k));
    end
    strobes(260, c);
    rdx(`PCS_OFF_COUNTERS, `PCS_RESP_OKAY, rd);
    chk({28'h0, rd[11:8]}, {28'h0, rd[7:4]});
    // slow channel, switched right after an update so no interval straddles it
    while (flt !== 1'b1) @(posedge ref_clk);
    wr(`PCS_OFF_CTRL, 32'h3, `PCS_RESP_OKAY);
    slow = 1'b1;
    strobes(400, c);
    go <= 1'b1;
    while (done !== 1'b1) @(posedge ref_clk);
    go <= 1'b0;
    rdx(`PCS_OFF_CAPTURE, `PCS_RESP_OKAY, rd);
    chk({16'h0, rd[15:0]}, {16'h0, rx_st, tx_st});
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
endmodule
bind pcs_timer pcs_timer_sva pcs_timer_sva_i (.REF_CLK(REF_CLK), .RST(RST),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .SAMPLE_STROBE(SAMPLE_STROBE), .CYCLE_START(CYCLE_START), .STAMP(STAMP), .SEQ_NUM(SEQ_NUM),
  .FILTER_STROBE(FILTER_STROBE));
`default_nettype wire
